// File: inc/ppl_pkg.sv
package ppl_pkg;
    // register offsets, packed {port D, port C, port B, port A}
    localparam logic [31:0] OFF_DIN  = {8'h11, 8'h10, 8'h01, 8'h00};
    localparam logic [31:0] OFF_DOUT = {8'h13, 8'h12, 8'h05, 8'h04};
    localparam logic [31:0] OFF_DIR  = {8'h15, 8'h14, 8'h07, 8'h06};
    localparam logic [31:0] OFF_CTL  = {8'h17, 8'h16, 8'h03, 8'h02};
    localparam logic [31:0] OFF_DRV  = {8'h1B, 8'h1A, 8'h09, 8'h08};
    localparam logic [31:0] OFF_OEN  = {8'h1D, 8'h1C, 8'h0D, 8'h0C};
    localparam logic [31:0] OFF_ISC  = {8'hFF, 8'h18, 8'h0B, 8'h0A};
    localparam logic [7:0]  OFF_MMC  = 8'h1E;
    // field layout
    localparam logic [7:0]  PORT_FULL_MASK = 8'hFF;
    localparam logic [7:0]  PC_GPIO_MASK   = 8'h9C;
    localparam logic [7:0]  PC_JTAG6_MASK  = 8'h18;
    localparam int          JTAG_STAT_BIT  = 3;
    localparam int          JTAG_ERR_BIT   = 4;
    localparam int          MMC_PIO_BIT    = 7;
    localparam logic [7:0]  MMC_WR_MASK    = 8'h80;
    // port capabilities, bit per port {D, C, B, A}
    localparam logic [3:0]  CAN_CELL = 4'hF;
    localparam logic [3:0]  CAN_ADDR = 4'h3;
    localparam logic [3:0]  CAN_PIO  = 4'h1;
    // reset values
    localparam logic [7:0]  REG_RST  = 8'h00;
    localparam logic        ISC_RST  = 1'b0;
    localparam logic [15:0] ADDR_RST = 16'h0000;

    typedef enum logic [1:0] {
        ISC_PASS,
        ISC_LATCH,
        ISC_REG,
        ISC_ALE
    } ppl_isc_mode_t;
endpackage

// File: rtl/ppl_port_pins.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: twenty strobe cells: A, B, four C
// R2: each cell passes, latches or registers
// R3: processor reads strobe cell outputs per port
// R4: one strobe term per four cells on A and B, per two cells on C
// R5: register on rising term, latch while high
// R6: address-latch mode gates with ALE
// R7: port C JTAG bits read zero
// R8: A,B eight bits, C four, D one/two
// R9: output mux: data, address, peripheral, cell
// R10: readback returns one of eight sources
// R11: output enable is term OR direction
// R12: without term, direction alone enables
// R13: pin read via data-in or strobe cell
// R14: mode availability limited per port
// R15: C0, C1, C5, C6 never general I/O
// R16: processor keeps control zero for plain I/O
// R17: processor sets bits for address/peripheral
// R18: direction ignored on cell-driven pin
// R19: six-pin JTAG: C3 status, C4 error
// R20: data-out ignored on cell pin; data-in reads
// R21: strobe cells clear on reset
module ppl_port_pins
    import ppl_pkg::*;
#(
    parameter int PD_W = 2
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    // configuration register access
    input  wire logic [7:0]      cfg_addr,
    input  wire logic            cfg_wr,
    input  wire logic            cfg_rd,
    input  wire logic [7:0]      cfg_wdata,
    output logic      [7:0]      cfg_rdata,
    // processor bus
    input  wire logic            ale,
    input  wire logic [15:0]     cpu_addr,
    input  wire logic [7:0]      periph_data,
    input  wire logic            periph_oe,
    // logic array outputs and enables
    input  wire logic [7:0]      pa_cell_out,
    input  wire logic [7:0]      pb_cell_out,
    input  wire logic [7:0]      pc_cell_out,
    input  wire logic [7:0]      pa_cell_sel,
    input  wire logic [7:0]      pb_cell_sel,
    input  wire logic [7:0]      pc_cell_sel,
    input  wire logic [7:0]      pt_oe_a,
    input  wire logic [7:0]      pt_oe_b,
    input  wire logic [7:0]      pt_oe_c,
    input  wire logic [7:0]      pt_oe_d,
    input  wire logic [PD_W-1:0] dec_cs,
    input  wire logic [PD_W-1:0] dec_cs_sel,
    // strobe cell setup and terms
    input  wire logic [31:0]     strobe_mode_ab,
    input  wire logic [7:0]      strobe_mode_c,
    input  wire logic [5:0]      strobe_clock_term,
    input  wire logic [5:0]      strobe_gate_term,
    // logic array input bus
    output logic      [7:0]      array_in_a,
    output logic      [7:0]      array_in_b,
    output logic      [7:0]      array_in_c,
    output logic      [PD_W-1:0] array_in_d,
    // jtag
    input  wire logic            jtag_six_pin,
    input  wire logic            jtag_status_pin,
    input  wire logic            jtag_error_pin,
    // pins
    input  wire logic [7:0]      pa_in,
    output logic      [7:0]      pa_out,
    output logic      [7:0]      pa_oe_n,
    input  wire logic [7:0]      pb_in,
    output logic      [7:0]      pb_out,
    output logic      [7:0]      pb_oe_n,
    input  wire logic [7:0]      pc_in,
    output logic      [7:0]      pc_out,
    output logic      [7:0]      pc_oe_n,
    input  wire logic [PD_W-1:0] pd_in,
    output logic      [PD_W-1:0] pd_out,
    output logic      [PD_W-1:0] pd_oe_n
);
    localparam logic [7:0] PD_MASK = 8'(((1 << PD_W) - 1) << 1);
    localparam logic [31:0] PORT_MASK =
        {PD_MASK, PC_GPIO_MASK, PORT_FULL_MASK, PORT_FULL_MASK};  // R8 R15

    function automatic logic [2:0] find_port(input logic [7:0] a,
                                             input logic [31:0] offs);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (a == offs[8*i +: 8]) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] pmask(input logic [1:0] p);
        return PORT_MASK[8*p +: 8];
    endfunction

    logic [3:0][7:0] dir_q;
    logic [3:0][7:0] drv_q;
    logic [3:0][7:0] ctl_q;
    logic [3:0][7:0] dout_q;
    logic [7:0]      mmc_q;
    logic [7:0]      rdata_q;
    logic [7:0]      rdata_d;
    logic [15:0]     lat_addr_q;
    logic [3:0][7:0] pin_in;
    logic [3:0][7:0] cell_val;
    logic [3:0][7:0] cell_sel;
    logic [3:0][7:0] pt_oe;
    logic [3:0][7:0] pin_val;
    logic [3:0][7:0] pin_oe;
    logic [3:0][7:0] isc_img;
    logic [15:0]     isc_ab;
    logic [1:0]      isc_c_lo;
    logic [1:0]      isc_c_hi;

    // pins land in both the port logic and the strobe cells
    assign pin_in   = {8'({pd_in, 1'b0}), pc_in & PC_GPIO_MASK,
                       pb_in, pa_in};  // R13 R7
    // chip selects use the cell path on port D
    assign cell_val = {8'({dec_cs, 1'b0}), pc_cell_out,
                       pb_cell_out, pa_cell_out};
    assign cell_sel = {8'({dec_cs_sel, 1'b0}), pc_cell_sel,
                       pb_cell_sel, pa_cell_sel};
    assign pt_oe    = {pt_oe_d | 8'({dec_cs_sel, 1'b0}), pt_oe_c,
                       pt_oe_b, pt_oe_a};

    // output mux and enable per port
    for (genvar p = 0; p < 4; p++) begin : g_port
        wire [7:0] m       = PORT_MASK[8*p +: 8];
        wire [7:0] by_cell = cell_sel[p] & m & {8{CAN_CELL[p]}};  // R14
        wire [7:0] by_pio  = {8{CAN_PIO[p] & mmc_q[MMC_PIO_BIT]}}
                             & m & ~by_cell;  // R14 R17
        wire [7:0] by_addr = ctl_q[p] & dir_q[p] & {8{CAN_ADDR[p]}}
                             & ~by_cell & ~by_pio;  // R17
        wire [7:0] by_reg  = ~by_cell & ~by_pio & ~by_addr;
        wire [7:0] lat     = (p == 0) ? lat_addr_q[7:0] : lat_addr_q[15:8];
        assign pin_val[p] = (by_cell & cell_val[p])      // R20
                          | (by_pio  & periph_data)
                          | (by_addr & lat)
                          | (by_reg  & dout_q[p]);       // R9
        assign pin_oe[p]  = m & ((by_cell & pt_oe[p])    // R18
                          | (by_pio & {8{periph_oe}})
                          | (~by_cell & ~by_pio
                             & (pt_oe[p] | dir_q[p])));  // R11 R12
    end

    wire [7:0] jt6 = jtag_six_pin ? PC_JTAG6_MASK : 8'h00;
    wire [7:0] jt_val = 8'({jtag_error_pin, jtag_status_pin}
                           << JTAG_STAT_BIT);
    wire [7:0] pc_oe  = pin_oe[2] | jt6;  // R15

    assign pa_out  = pin_val[0];
    assign pa_oe_n = ~pin_oe[0];
    assign pb_out  = pin_val[1];
    assign pb_oe_n = ~pin_oe[1];
    assign pc_out  = (pin_val[2] & ~jt6) | (jt_val & jt6);  // R19
    assign pc_oe_n = ~pc_oe;
    assign pd_out  = pin_val[3][PD_W:1];
    assign pd_oe_n = ~pin_oe[3][PD_W:1];

    // strobe cells: ports A and B in groups of four
    for (genvar g = 0; g < 4; g++) begin : g_isc
        ppl_strobe_group #(.W(4)) u_grp (  // R1 R4
            .clk       (clk),
            .resetn    (resetn),
            .pin       (pin_in[g/2][4*(g%2) +: 4]),
            .mode      (strobe_mode_ab[8*g +: 8]),
            .clk_term  (strobe_clock_term[g]),
            .gate_term (strobe_gate_term[g]),
            .ale       (ale),
            .q_out     (isc_ab[4*g +: 4])
        );
    end

    // port C cells: bits 2,3 share the low term, 4,7 the high term
    ppl_strobe_group #(.W(2)) u_isc_c_lo (  // R1 R4
        .clk       (clk),
        .resetn    (resetn),
        .pin       (pc_in[3:2]),
        .mode      (strobe_mode_c[3:0]),
        .clk_term  (strobe_clock_term[4]),
        .gate_term (strobe_gate_term[4]),
        .ale       (ale),
        .q_out     (isc_c_lo)
    );
    ppl_strobe_group #(.W(2)) u_isc_c_hi (
        .clk       (clk),
        .resetn    (resetn),
        .pin       ({pc_in[7], pc_in[4]}),
        .mode      (strobe_mode_c[7:4]),
        .clk_term  (strobe_clock_term[5]),
        .gate_term (strobe_gate_term[5]),
        .ale       (ale),
        .q_out     (isc_c_hi)
    );

    assign isc_img = {8'h00,
                      {isc_c_hi[1], 2'b00, isc_c_hi[0], isc_c_lo, 2'b00},
                      isc_ab[15:8], isc_ab[7:0]};  // R7
    assign array_in_a = isc_img[0];
    assign array_in_b = isc_img[1];
    assign array_in_c = isc_img[2];
    assign array_in_d = pd_in;

    // register decode
    wire [2:0] h_din  = find_port(cfg_addr, OFF_DIN);
    wire [2:0] h_dout = find_port(cfg_addr, OFF_DOUT);
    wire [2:0] h_dir  = find_port(cfg_addr, OFF_DIR);
    wire [2:0] h_ctl  = find_port(cfg_addr, OFF_CTL);
    wire [2:0] h_drv  = find_port(cfg_addr, OFF_DRV);
    wire [2:0] h_oen  = find_port(cfg_addr, OFF_OEN);
    wire [2:0] h_isc  = find_port(cfg_addr, OFF_ISC);
    wire       h_mmc  = (cfg_addr == OFF_MMC);

    // readback buffer: one source per read
    assign rdata_d =
          h_din[2]  ? pin_in[h_din[1:0]]                // R13
        : h_dout[2] ? dout_q[h_dout[1:0]]
        : h_dir[2]  ? dir_q[h_dir[1:0]]
        : h_ctl[2]  ? ctl_q[h_ctl[1:0]]
        : h_drv[2]  ? drv_q[h_drv[1:0]]
        : h_oen[2]  ? (h_oen[1:0] == 2'h2 ? pc_oe
                                          : pin_oe[h_oen[1:0]])
        : h_isc[2]  ? isc_img[h_isc[1:0]]               // R3
        : h_mmc     ? mmc_q
        : 8'h00;                                        // R10

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dir_q   <= {4{REG_RST}};
            drv_q   <= {4{REG_RST}};
            ctl_q   <= {4{REG_RST}};
            dout_q  <= {4{REG_RST}};
            mmc_q   <= REG_RST;
            rdata_q <= REG_RST;
        end else begin
            if (cfg_rd) begin
                rdata_q <= rdata_d;
            end
            if (cfg_wr && h_dir[2]) begin
                dir_q[h_dir[1:0]] <= cfg_wdata & pmask(h_dir[1:0]);
            end
            if (cfg_wr && h_drv[2]) begin
                drv_q[h_drv[1:0]] <= cfg_wdata & pmask(h_drv[1:0]);
            end
            if (cfg_wr && h_ctl[2]) begin
                ctl_q[h_ctl[1:0]] <= cfg_wdata & pmask(h_ctl[1:0]);
            end
            if (cfg_wr && h_dout[2]) begin
                dout_q[h_dout[1:0]] <= cfg_wdata & pmask(h_dout[1:0]);
            end
            if (cfg_wr && h_mmc) begin
                mmc_q <= cfg_wdata & MMC_WR_MASK;
            end
        end
    end
    assign cfg_rdata = rdata_q;

    // address latch follows the bus while ALE is high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lat_addr_q <= ADDR_RST;
        end else if (ale) begin
            lat_addr_q <= cpu_addr;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_dir_b_wr;
        cfg_wr && cfg_addr == OFF_DIR[15:8];
    endsequence
    sequence s_dir_b_rd;
        cfg_rd && !cfg_wr && cfg_addr == OFF_DIR[15:8];
    endsequence

    a_oe_or_dir: assert property ( // R11
        !pb_cell_sel[0] |-> (!pb_oe_n[0] == (pt_oe_b[0] | dir_q[1][0])))
        else $error("output enable is not term or direction");
    a_cell_no_dir: assert property ( // R18
        pb_cell_sel[1] |-> pb_out[1] == pb_cell_out[1]
                        && !pb_oe_n[1] == pt_oe_b[1])
        else $error("cell pin follows register settings");
    a_jtag_never: assert property ( // R15
        pc_oe_n[0] && pc_oe_n[1] && pc_oe_n[5] && pc_oe_n[6])
        else $error("jtag pin driven as general output");
    a_six_pin_status: assert property ( // R19
        jtag_six_pin |-> !pc_oe_n[3] && !pc_oe_n[4]
                      && pc_out[3] == jtag_status_pin
                      && pc_out[4] == jtag_error_pin)
        else $error("jtag status or error pin wrong");
    a_strobe_read: assert property ( // R3
        cfg_rd && cfg_addr == OFF_ISC[15:8] |=> cfg_rdata == $past(isc_ab[15:8]))
        else $error("port B strobe readback wrong");
    a_dir_readback: assert property ( // R10
        s_dir_b_wr ##1 s_dir_b_rd |=> cfg_rdata == $past(cfg_wdata, 2))
        else $error("direction readback differs from write");
    a_pio_mux: assert property ( // R9
        mmc_q[MMC_PIO_BIT] && !pa_cell_sel[0] |-> pa_out[0] == periph_data[0]
                                              && !pa_oe_n[0] == periph_oe)
        else $error("peripheral data not on port A");
    a_addr_out: assert property ( // R6
        ale ##1 (!ale && ctl_q[1][2] && dir_q[1][2] && !pb_cell_sel[2])
        |-> pb_out[2] == $past(cpu_addr[10]))
        else $error("latched address not on port B");
    a_din_pin: assert property ( // R13
        cfg_rd && cfg_addr == OFF_DIN[7:0] |=> cfg_rdata == $past(pa_in))
        else $error("data-in does not read port A pin");
endmodule
`default_nettype wire

// File: rtl/ppl_strobe_group.sv
`timescale 1ns/1ps
`default_nettype none
module ppl_strobe_group
    import ppl_pkg::*;
#(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           resetn,
    // pins and per-cell mode
    input  wire logic [W-1:0]   pin,
    input  wire logic [2*W-1:0] mode,
    // shared strobe terms
    input  wire logic           clk_term,
    input  wire logic           gate_term,
    input  wire logic           ale,
    // towards the logic array
    output logic      [W-1:0]   q_out
);
    logic         term_q;
    logic [W-1:0] hold_q;
    logic [W-1:0] hold_d;
    wire          term_rise = clk_term & ~term_q;

    for (genvar i = 0; i < W; i++) begin : g_cell
        wire ppl_isc_mode_t m = ppl_isc_mode_t'(mode[2*i +: 2]);
        wire take = (m == ISC_REG   && term_rise)   // R5 R4
                 || (m == ISC_LATCH && gate_term)   // R5
                 || (m == ISC_ALE   && ale);        // R6
        assign hold_d[i] = take ? pin[i] : hold_q[i];
        // transparent latch passes the pin while open
        assign q_out[i] = (m == ISC_PASS)  ? pin[i]                  // R2
                        : (m == ISC_LATCH) ? (gate_term ? pin[i] : hold_q[i])
                        : (m == ISC_ALE)   ? (ale ? pin[i] : hold_q[i])
                        : hold_q[i];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            term_q <= 1'b0;
            hold_q <= {W{ISC_RST}};  // R21
        end else begin
            term_q <= clk_term;
            hold_q <= hold_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_reg_capture: assert property ( // R5
        (ppl_isc_mode_t'(mode[1:0]) == ISC_REG && clk_term && !term_q)
        ##1 (ppl_isc_mode_t'(mode[1:0]) == ISC_REG && !clk_term)
        |-> q_out[0] == $past(pin[0]))
        else $error("clocked cell missed rising term");
    a_pass_cell: assert property ( // R2
        ppl_isc_mode_t'(mode[1:0]) == ISC_PASS |-> q_out[0] == pin[0])
        else $error("pass cell does not follow pin");
endmodule
`default_nettype wire

// File: testbench/ppl_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppl_pad_model #(
    parameter int W = 8
) (
    // pad side of the block
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe_n,
    // far side drive
    input  wire logic [W-1:0] ext,
    output logic      [W-1:0] lvl
);
    // driven bits follow the block, released bits the outside
    always_comb begin
        for (int i = 0; i < W; i++) begin
            lvl[i] = oe_n[i] ? ext[i] : out[i];
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import ppl_pkg::*;
;
    localparam int PD_W = 2;
    logic            clk, resetn, cfg_wr, cfg_rd, ale, periph_oe;
    logic            jtag_six_pin, jtag_status_pin, jtag_error_pin;
    logic [7:0]      cfg_addr, cfg_wdata, periph_data, pa_cell_out, pb_cell_out;
    logic [7:0]      pc_cell_out, pa_cell_sel, pb_cell_sel, pc_cell_sel, strobe_mode_c;
    logic [7:0]      pt_oe_a, pt_oe_b, pt_oe_c, pt_oe_d, pa_ext, pb_ext, pc_ext;
    logic [7:0]      d, v, e, o;
    logic [15:0]     cpu_addr, ad;
    logic [31:0]     strobe_mode_ab, rs;
    logic [31:0]     offs [4];
    logic [5:0]      strobe_clock_term, strobe_gate_term;
    logic [PD_W-1:0] dec_cs, dec_cs_sel, pd_ext;
    int              num_errors, samples_checked;
    wire  [7:0]      cfg_rdata, array_in_a, array_in_b, array_in_c;
    wire  [7:0]      pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n, pc_in, pc_out, pc_oe_n;
    wire  [PD_W-1:0] array_in_d, pd_in, pd_out, pd_oe_n;

    ppl_port_pins #(.PD_W(PD_W)) u_ppl_port_pins (
        .clk, .resetn, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata,
        .ale, .cpu_addr, .periph_data, .periph_oe, .pa_cell_out, .pb_cell_out,
        .pc_cell_out, .pa_cell_sel, .pb_cell_sel, .pc_cell_sel, .pt_oe_a, .pt_oe_b,
        .pt_oe_c, .pt_oe_d, .dec_cs, .dec_cs_sel, .strobe_mode_ab, .strobe_mode_c,
        .strobe_clock_term, .strobe_gate_term, .array_in_a, .array_in_b, .array_in_c,
        .array_in_d, .jtag_six_pin, .jtag_status_pin, .jtag_error_pin, .pa_in, .pa_out,
        .pa_oe_n, .pb_in, .pb_out, .pb_oe_n, .pc_in, .pc_out, .pc_oe_n, .pd_in, .pd_out,
        .pd_oe_n
    );
    ppl_pad_model #(.W(8)) u_pad_a (.out(pa_out), .oe_n(pa_oe_n), .ext(pa_ext), .lvl(pa_in));
    ppl_pad_model #(.W(8)) u_pad_b (.out(pb_out), .oe_n(pb_oe_n), .ext(pb_ext), .lvl(pb_in));
    ppl_pad_model #(.W(8)) u_pad_c (.out(pc_out), .oe_n(pc_oe_n), .ext(pc_ext), .lvl(pc_in));
    ppl_pad_model #(.W(PD_W)) u_pad_d (.out(pd_out), .oe_n(pd_oe_n), .ext(pd_ext), .lvl(pd_in));

    always #25 clk = ~clk;

    function automatic logic [7:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction

    function automatic logic [7:0] port_mask(input int p);
        return p == 2 ? PC_GPIO_MASK : p == 3 ? 8'(((1 << PD_W) - 1) << 1) : PORT_FULL_MASK;
    endfunction

    function automatic logic [7:0] pin_lvl(input logic [7:0] oe, out, ext);
        return (oe & out) | (~oe & ext);
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(negedge clk);
        cfg_addr = a;
        cfg_wdata = dat;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clk);
        cfg_rd = 1'b0;
        chk(cfg_rdata, exp);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(50 * 5000);
        num_errors++;
        complete_run();
    end

    initial begin
        rs = 32'h58;
        clk = 1'b0;
        resetn = 1'b0;
        {cfg_wr, cfg_rd, ale, periph_oe, jtag_six_pin, jtag_status_pin, jtag_error_pin} = '0;
        {pa_cell_sel, pb_cell_sel, pc_cell_sel, pt_oe_a, pt_oe_b, pt_oe_c, pt_oe_d} = '0;
        {cfg_addr, cfg_wdata, periph_data, strobe_clock_term, strobe_gate_term} = '0;
        {pa_cell_out, pb_cell_out, pc_cell_out, cpu_addr} = {rnd(), rnd(), rnd(), rnd(), rnd()};
        {pa_ext, pb_ext, pc_ext, d} = {rnd(), rnd(), rnd(), rnd()};
        {pd_ext, dec_cs, dec_cs_sel} = d[3*PD_W-1:0];
        strobe_mode_ab = {16{2'h2}};
        strobe_mode_c = {4{2'h2}};
        offs = '{OFF_DOUT, OFF_DIR, OFF_CTL, OFF_DRV};
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        chk(array_in_a, 8'h00);
        chk(array_in_b, 8'h00);
        dec_cs_sel = '0;
        // settings: reset value, masked write, readback
        for (int p = 0; p < 4; p++) begin
            for (int r = 0; r < 4; r++) begin
                d = rnd();
                rdchk(offs[r][8*p+:8], 8'h00);
                wr(offs[r][8*p+:8], d);
                rdchk(offs[r][8*p+:8], d & port_mask(p));
                wr(offs[r][8*p+:8], 8'h00);
            end
        end
        // back-to-back write and read of port B direction
        d = rnd();
        @(negedge clk);
        {cfg_addr, cfg_wdata, cfg_wr} = {OFF_DIR[15:8], d, 1'b1};
        @(negedge clk);
        {cfg_wr, cfg_rd} = 2'b01;
        @(negedge clk);
        cfg_rd = 1'b0;
        chk(cfg_rdata, d);
        wr(OFF_DIR[15:8], 8'h00);
        rdchk(8'hFF, 8'h00);
        // output enable, data-out and pin readback
        for (int k = 0; k < 8; k++) begin
            {d, v, e, o} = {rnd(), rnd(), rnd(), rnd()};
            pt_oe_a = v;
            pa_ext = e;
            wr(OFF_DIR[7:0], d);
            wr(OFF_DOUT[7:0], o);
            chk(pa_oe_n, ~(d | v));
            chk(pa_out, o);
            rdchk(OFF_DIN[7:0], pin_lvl(d | v, o, e));
            rdchk(OFF_OEN[7:0], d | v);
        end
        pt_oe_a = 8'h00;
        @(negedge clk);
        chk(pa_oe_n, ~d);
        // cell output overrides direction and data-out
        pa_cell_sel = 8'hFF;
        pb_cell_sel = 8'hFF;
        v = rnd();
        pt_oe_a = v;
        pt_oe_b = v;
        @(negedge clk);
        chk(pa_out, pa_cell_out);
        chk(pa_oe_n, ~v);
        chk(pb_out, pb_cell_out);
        pa_cell_sel = 8'h00;
        pb_cell_sel = 8'h00;
        pt_oe_a = 8'h00;
        pt_oe_b = 8'h00;
        // peripheral data on port A
        wr(OFF_MMC, 8'h80);
        periph_data = rnd();
        periph_oe = 1'b1;
        @(negedge clk);
        chk(pa_out, periph_data);
        chk(pa_oe_n, 8'h00);
        periph_oe = 1'b0;
        wr(OFF_MMC, 8'h00);
        // latched address on ports A and B
        for (int p = 0; p < 2; p++) begin
            wr(OFF_CTL[8*p+:8], 8'hFF);
            wr(OFF_DIR[8*p+:8], 8'hFF);
        end
        ale = 1'b1;
        cpu_addr = {rnd(), rnd()};
        ad = cpu_addr;
        @(negedge clk);
        ale = 1'b0;
        cpu_addr = ~ad;
        @(negedge clk);
        chk(pa_out, ad[7:0]);
        chk(pb_out, ad[15:8]);
        for (int p = 0; p < 3; p++) begin
            wr(OFF_CTL[8*p+:8], 8'h00);
            wr(OFF_DIR[8*p+:8], 8'h00);
        end
        // clocked cells B0-3 then B4-7, each term rises once
        pb_ext = rnd();
        e = pb_ext;
        strobe_clock_term[2] = 1'b1;
        @(negedge clk);
        pb_ext = ~e;
        @(negedge clk);
        chk(array_in_b, {4'h0, e[3:0]});
        rdchk(OFF_ISC[15:8], {4'h0, e[3:0]});
        strobe_clock_term[3] = 1'b1;
        @(negedge clk);
        chk(array_in_b, {~e[7:4], e[3:0]});
        strobe_clock_term = '0;
        // latched A0-3, pass A4-7
        strobe_mode_ab[15:0] = {8'h00, {4{2'h1}}};
        strobe_gate_term[0] = 1'b1;
        pa_ext = rnd();
        e = pa_ext;
        @(negedge clk);
        chk(array_in_a, e);
        strobe_gate_term[0] = 1'b0;
        pa_ext = ~e;
        @(negedge clk);
        chk(array_in_a, {~e[7:4], e[3:0]});
        // address-latch strobe on port C cells
        strobe_mode_c = 8'hFF;
        ale = 1'b1;
        pc_ext = rnd();
        e = pc_ext;
        @(negedge clk);
        ale = 1'b0;
        pc_ext = ~e;
        @(negedge clk);
        chk(array_in_c, e & PC_GPIO_MASK);
        rdchk(OFF_ISC[23:16], e & PC_GPIO_MASK);
        rdchk(OFF_DIN[23:16], ~e & PC_GPIO_MASK);
        // six-pin debug status and error
        jtag_six_pin = 1'b1;
        {jtag_status_pin, jtag_error_pin} = 2'h1;
        @(negedge clk);
        chk({6'h00, pc_out[4:3]}, 8'h02);
        chk({6'h00, pc_oe_n[4:3]}, 8'h00);
        jtag_six_pin = 1'b0;
        // chip select drives port D bit 1, bit 2 released
        d = rnd();
        {dec_cs, pd_ext} = d[2*PD_W-1:0];
        dec_cs_sel = 2'h1;
        @(negedge clk);
        chk({6'h00, pd_oe_n}, {6'h00, ~dec_cs_sel});
        chk({6'h00, pd_out}, {6'h00, dec_cs & dec_cs_sel});
        chk({6'h00, array_in_d},
            pin_lvl({6'h00, dec_cs_sel}, {6'h00, dec_cs}, {6'h00, pd_ext}));
        complete_run();
    end
endmodule
`default_nettype wire
